/* design/host_reset_consts.svh */
/*
 * Offsets, field positions, reset values and timing counts of the host reset sequencer.
 * Assumes a 100 MHz host clock and byte addresses on the software register port.
 */
`ifndef HOST_RESET_CONSTS_SVH
`define HOST_RESET_CONSTS_SVH

// software register map, byte addresses
`define REG_CONFIG        8'h00
`define REG_STATUS        8'h04
`define REG_MASK          8'h08
`define REG_STATE         8'h0c

// config register fields
`define CFG_NAND_BIT      0
`define CFG_ECC_MODE_LSB  7
`define CFG_ECC_MODE_MSB  8
`define CFG_WRITE_MASK    32'h0000_0181
`define CONFIG_RESET      32'h0000_0000
`define ECC_MODE_NONE     2'h0

// status and mask register fields
`define ST_SINGLE_BIT     0
`define ST_MULTI_BIT      1
`define ST_RESET_DONE     2
`define ST_WIDTH          3
`define MASK_RESET        3'h0

// timing
`define CLK_PERIOD_NS     10
`define HOLD_TIME_US      1000
`define HOLD_CYCLES       ((`HOLD_TIME_US * 1000) / `CLK_PERIOD_NS)
`define HOLD_CNT_W        17
`define TAIL_LAST         17'h00001
`define REQ_PCI_CYCLES    8
`define REQ_CNT_W         16

`endif

/* design/host_reset_pkg.sv */
/*
 * Types shared by both ends of the host reset link.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package host_reset_pkg;

	typedef enum logic [1:0] {
		ST_REQ  = 2'b00,
		ST_HOLD = 2'b01,
		ST_TAIL = 2'b10,
		ST_RUN  = 2'b11
	} seq_state_e;

	typedef enum logic [0:0] {
		BR_IDLE   = 1'b0,
		BR_ASSERT = 1'b1
	} bridge_state_e;

endpackage

/* design/host_reset_if.sv */
/*
 * Link between the reset sequencer and the I/O bridge with its clock source.
 * Assumes weak pull-ups on undriven active-low lines; resolves levels from the enables.
 */
interface host_reset_if;

	logic pci_clock_in;
	logic reset_request_in_n;
	logic test_mode_select_n;
	logic processor_reset_out_n;
	logic processor_reset_oe;
	logic delayed_chip_reset_n;
	logic delayed_chip_reset_oe;
	logic ecc_error_out_n;
	logic ecc_error_oe;
	logic symmetric_agent_request_n;
	logic symmetric_agent_request_oe;

	// wire levels seen by the far end
	logic processor_reset_level_n;
	logic delayed_chip_reset_level_n;
	logic ecc_error_level_n;
	logic symmetric_agent_request_level_n;

	assign processor_reset_level_n         = processor_reset_oe ? processor_reset_out_n : 1'b1;
	assign delayed_chip_reset_level_n      = delayed_chip_reset_oe ? delayed_chip_reset_n : 1'b1;
	assign ecc_error_level_n               = ecc_error_oe ? ecc_error_out_n : 1'b1;
	assign symmetric_agent_request_level_n = symmetric_agent_request_oe ? symmetric_agent_request_n : 1'b1;

	modport device (
		input  pci_clock_in,
		input  reset_request_in_n,
		input  test_mode_select_n,
		output processor_reset_out_n,
		output processor_reset_oe,
		output delayed_chip_reset_n,
		output delayed_chip_reset_oe,
		output ecc_error_out_n,
		output ecc_error_oe,
		output symmetric_agent_request_n,
		output symmetric_agent_request_oe
	);

	modport bridge (
		output pci_clock_in,
		output reset_request_in_n,
		output test_mode_select_n,
		input  processor_reset_level_n,
		input  delayed_chip_reset_level_n,
		input  ecc_error_level_n,
		input  symmetric_agent_request_level_n
	);

endinterface

/* design/reset_sync.sv */
/*
 * Two-stage synchroniser for one level into the host clock domain.
 * Assumes the input may change at any host edge; powers up reading as asserted.
 */
module reset_sync (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic async_in,
	output logic      sync_out
);

	logic meta_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r   <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

/* design/host_reset_sequencer.sv */
/*
 * Device end: processor reset sequencer, delayed chip reset, symmetric-agent
 * request, ECC error output with software status/mask registers, test modes.
 * Assumes clk is the buffered host clock and the bridge drives its reset request
 * aligned to the divided PCI clock.
 */
// The strobed register port and the placing of the registers were chosen for this implementation.
// Contract
// - host-domain logic clocked only by host clock
// - PCI clock is host clock divided by two
// - bridge drives request synchronous to PCI clock
// - request used for power-on and software resets
// - request asserted makes processor reset assert
// - processor reset held 1 ms after release
// - chip reset follows, releases 2 clocks later
// - ECC error output on single or multi-bit
// - ECC error holds until software clears flags
// - ECC mode 00 keeps ECC error masked
// - agent request asserted with processor reset
// - agent request releases 2 clocks after reset
// - test input selects tri-state or NAND tree
// - agent request floats after its hold
// - request also resets graphics-port logic
`include "host_reset_consts.svh"

module host_reset_sequencer
	import host_reset_pkg::*;
#(
	parameter int HOLD_CYCLES = `HOLD_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	host_reset_if.device    link,
	input  wire logic [7:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic [31:0]     rdata,
	input  wire logic       ecc_single_err,
	input  wire logic       ecc_multi_err,
	output logic            irq,
	output logic            gport_reset_n,
	output logic            nand_tree_out
);

	localparam logic [`HOLD_CNT_W-1:0] HOLD_LAST = `HOLD_CNT_W'(HOLD_CYCLES - 1);

	seq_state_e              state_r;
	seq_state_e              state_nxt;
	logic [`HOLD_CNT_W-1:0]  cnt_r;
	logic                    req_s;
	logic [31:0]             config_r;
	logic [`ST_WIDTH-1:0]    status_r;
	logic [`ST_WIDTH-1:0]    status_nxt;
	logic [`ST_WIDTH-1:0]    events;
	logic [`ST_WIDTH-1:0]    mask_r;
	logic                    cpu_rst_r;
	logic                    chip_rst_r;
	logic                    agent_req_r;
	logic                    agent_oe_r;
	logic                    ecc_err_r;
	logic                    test_r;
	logic                    nand_r;
	logic                    gport_rst_r;
	logic                    float_outs;
	logic [1:0]              ecc_mode;

	// address decode shared by write and read paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_off);
		hit = (a == reg_off);
	endfunction

	// true in states where the chip reset and agent request are still active
	function automatic logic in_reset_tail(input seq_state_e st);
		in_reset_tail = (st != ST_RUN);
	endfunction

	// request brought into the host domain
	reset_sync u_req_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (~link.reset_request_in_n),
		.sync_out (req_s)
	);

	assign ecc_mode = config_r[`CFG_ECC_MODE_MSB:`CFG_ECC_MODE_LSB];

	// sequence: request, 1 ms hold, 2-clock tail, run
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_REQ: begin
				if (!req_s) begin
					state_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (req_s) begin
					state_nxt = ST_REQ;
				end else if (cnt_r == HOLD_LAST) begin
					state_nxt = ST_TAIL;
				end
			end
			ST_TAIL: begin
				if (req_s) begin
					state_nxt = ST_REQ;
				end else if (cnt_r == `TAIL_LAST) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (req_s) begin
					state_nxt = ST_REQ;
				end
			end
			default: begin
				state_nxt = ST_REQ;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_REQ;
		end else begin
			state_r <= state_nxt;
		end
	end

	// cycle counter restarts on every state change
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= '0;
		end else if (state_nxt != state_r) begin
			cnt_r <= '0;
		end else if (state_r == ST_HOLD || state_r == ST_TAIL) begin
			cnt_r <= cnt_r + `HOLD_CNT_W'(1);
		end
	end

	// reset outputs, registered from the next state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_rst_r   <= 1'b1;
			chip_rst_r  <= 1'b1;
			agent_req_r <= 1'b1;
			agent_oe_r  <= 1'b1;
		end else begin
			cpu_rst_r   <= (state_nxt == ST_REQ) || (state_nxt == ST_HOLD);
			chip_rst_r  <= in_reset_tail(state_nxt);
			agent_req_r <= in_reset_tail(state_nxt);
			agent_oe_r  <= in_reset_tail(state_nxt);
		end
	end

	// graphics-port logic follows the request directly
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gport_rst_r <= 1'b1;
		end else begin
			gport_rst_r <= req_s;
		end
	end

	// config and mask registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			config_r <= `CONFIG_RESET;
		end else if (wr && hit(addr, `REG_CONFIG)) begin
			config_r <= wdata & `CFG_WRITE_MASK;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_r <= `MASK_RESET;
		end else if (wr && hit(addr, `REG_MASK)) begin
			mask_r <= wdata[`ST_WIDTH-1:0];
		end
	end

	// sticky status; a read clears, a same-cycle event wins
	always_comb begin
		events                 = '0;
		events[`ST_SINGLE_BIT] = ecc_single_err;
		events[`ST_MULTI_BIT]  = ecc_multi_err;
		events[`ST_RESET_DONE] = (state_r == ST_TAIL) && (state_nxt == ST_RUN);
		status_nxt             = status_r;
		if (rd && hit(addr, `REG_STATUS)) begin
			status_nxt = '0;
		end
		status_nxt = status_nxt | events;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status_r <= '0;
		end else begin
			status_r <= status_nxt;
		end
	end

	// ecc error pin: held by status flags, masked in non-ECC mode
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ecc_err_r <= 1'b0;
		end else begin
			ecc_err_r <= (status_nxt[`ST_SINGLE_BIT] || status_nxt[`ST_MULTI_BIT])
				&& (ecc_mode != `ECC_MODE_NONE);
		end
	end

	// test modes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			test_r <= 1'b0;
			nand_r <= 1'b0;
		end else begin
			test_r <= ~link.test_mode_select_n;
			if (test_r && config_r[`CFG_NAND_BIT]) begin
				nand_r <= ~&{link.reset_request_in_n, ecc_single_err, ecc_multi_err, wr, rd};
			end else begin
				nand_r <= 1'b0;
			end
		end
	end

	assign float_outs = test_r && !config_r[`CFG_NAND_BIT];

	// read port, data one cycle after the strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= '0;
		end else if (rd) begin
			if (hit(addr, `REG_CONFIG)) begin
				rdata <= config_r;
			end else if (hit(addr, `REG_STATUS)) begin
				rdata <= {29'h0000_0000, status_r};
			end else if (hit(addr, `REG_MASK)) begin
				rdata <= {29'h0000_0000, mask_r};
			end else if (hit(addr, `REG_STATE)) begin
				rdata <= {24'h00_0000, 1'b0, test_r, req_s, agent_oe_r, cpu_rst_r, chip_rst_r, state_r};
			end else begin
				rdata <= '0;
			end
		end else begin
			rdata <= '0;
		end
	end

	assign irq           = |(status_r & mask_r);
	assign gport_reset_n = ~gport_rst_r;
	assign nand_tree_out = nand_r;

	assign link.processor_reset_out_n     = ~cpu_rst_r;
	assign link.processor_reset_oe        = ~float_outs;
	assign link.delayed_chip_reset_n      = ~chip_rst_r;
	assign link.delayed_chip_reset_oe     = ~float_outs;
	assign link.ecc_error_out_n           = ~ecc_err_r;
	assign link.ecc_error_oe              = ~float_outs;
	assign link.symmetric_agent_request_n = ~agent_req_r;
	assign link.symmetric_agent_request_oe = agent_oe_r && !float_outs;

endmodule

/* design/io_bridge_end.sv */
/*
 * Far end: clock source dividing the host clock by two and the I/O bridge
 * driving the reset request on the divided clock.
 * Assumes clk is the same host clock that feeds the sequencer.
 */
`include "host_reset_consts.svh"

module io_bridge_end
	import host_reset_pkg::*;
(
	input  wire logic clk,
	input  wire logic reset_n,
	host_reset_if.bridge link,
	input  wire logic sw_reset_req,
	input  wire logic test_mode_req,
	output logic      cpu_in_reset,
	output logic      chip_in_reset,
	output logic      agent_config_active,
	output logic      ecc_alarm
);

	localparam logic [`REQ_CNT_W-1:0] REQ_LAST = `REQ_CNT_W'(`REQ_PCI_CYCLES - 1);

	bridge_state_e          state_r;
	logic [`REQ_CNT_W-1:0]  cnt_r;
	logic                   pci_r;
	logic                   pend_r;
	logic                   pci_rise;
	logic                   test_r;
	logic [3:0]             seen_r;

	// divide-by-two pci clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pci_r <= 1'b0;
		end else begin
			pci_r <= ~pci_r;
		end
	end

	assign pci_rise = ~pci_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_r <= 1'b0;
		end else if (sw_reset_req) begin
			pend_r <= 1'b1;
		end else if (pci_rise && state_r == BR_IDLE) begin
			pend_r <= 1'b0;
		end
	end

	// request changes only with a pci clock rising edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= BR_ASSERT;
			cnt_r   <= '0;
		end else if (pci_rise) begin
			case (state_r)
				BR_ASSERT: begin
					if (cnt_r == REQ_LAST) begin
						state_r <= BR_IDLE;
					end else begin
						cnt_r <= cnt_r + `REQ_CNT_W'(1);
					end
				end
				BR_IDLE: begin
					if (pend_r) begin
						state_r <= BR_ASSERT;
						cnt_r   <= '0;
					end
				end
				default: begin
					state_r <= BR_ASSERT;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			test_r <= 1'b0;
			seen_r <= 4'h0;
		end else begin
			test_r <= test_mode_req;
			seen_r <= {~link.processor_reset_level_n, ~link.delayed_chip_reset_level_n,
				~link.symmetric_agent_request_level_n, ~link.ecc_error_level_n};
		end
	end

	assign link.pci_clock_in       = pci_r;
	assign link.reset_request_in_n = ~(state_r == BR_ASSERT);
	assign link.test_mode_select_n = ~test_r;
	assign cpu_in_reset            = seen_r[3];
	assign chip_in_reset           = seen_r[2];
	assign agent_config_active     = seen_r[1];
	assign ecc_alarm               = seen_r[0];

endmodule

/* dv/host_reset_chk.sv */
/*
 * Concurrent checks on the link between the reset sequencer and the I/O bridge.
 * Assumes one host clock, an active-low asynchronous reset and the shortened hold count.
 */
`include "host_reset_consts.svh"

module host_reset_chk #(
	parameter int HOLD_CYCLES = 20
) (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic [7:0] addr,
	input wire logic       rd,
	input wire logic       ecc_single_err,
	input wire logic       ecc_multi_err,
	input wire logic       pci_clock_in,
	input wire logic       reset_request_in_n,
	input wire logic       test_mode_select_n,
	input wire logic       processor_reset_out_n,
	input wire logic       delayed_chip_reset_n,
	input wire logic       ecc_error_out_n,
	input wire logic       symmetric_agent_request_n,
	input wire logic       symmetric_agent_request_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] hi_cnt_r;

	// cycles since the request was last seen asserted
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			hi_cnt_r <= 16'h0000;
		else if (!reset_request_in_n)
			hi_cnt_r <= 16'h0000;
		else if (hi_cnt_r != 16'hffff)
			hi_cnt_r <= hi_cnt_r + 16'h0001;
	end

	default clocking dc @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_req_to_cpu;
		$fell(reset_request_in_n) |-> ##[2:3] !processor_reset_out_n;
	endproperty
	a_req_to_cpu: assert property (p_req_to_cpu)
		else $error("processor reset not raised by request");

	property p_hold_len;
		$rose(processor_reset_out_n) |-> hi_cnt_r >= 16'(HOLD_CYCLES + 2) && hi_cnt_r <= 16'(HOLD_CYCLES + 4);
	endproperty
	a_hold_len: assert property (p_hold_len)
		else $error("processor reset hold length wrong");

	property p_chip_with_cpu;
		!processor_reset_out_n |-> !delayed_chip_reset_n;
	endproperty
	a_chip_with_cpu: assert property (p_chip_with_cpu)
		else $error("chip reset not asserted with processor reset");

	property p_chip_tail;
		$rose(processor_reset_out_n) |-> !delayed_chip_reset_n ##1 !delayed_chip_reset_n ##1 delayed_chip_reset_n;
	endproperty
	a_chip_tail: assert property (p_chip_tail)
		else $error("chip reset release not two cycles late");

	property p_agent_with_cpu;
		!processor_reset_out_n && test_mode_select_n |-> !symmetric_agent_request_n;
	endproperty
	a_agent_with_cpu: assert property (p_agent_with_cpu)
		else $error("agent request not asserted with processor reset");

	property p_agent_release;
		$rose(processor_reset_out_n) && test_mode_select_n |-> !symmetric_agent_request_n ##1
			!symmetric_agent_request_n ##1 (symmetric_agent_request_n && !symmetric_agent_request_oe);
	endproperty
	a_agent_release: assert property (p_agent_release)
		else $error("agent request release timing wrong");

	property p_ecc_stays;
		!ecc_error_out_n && !(rd && addr == `REG_STATUS) |=> !ecc_error_out_n;
	endproperty
	a_ecc_stays: assert property (p_ecc_stays)
		else $error("ecc error dropped without status read");

	property p_ecc_clear;
		rd && addr == `REG_STATUS && !ecc_single_err && !ecc_multi_err |=> ecc_error_out_n;
	endproperty
	a_ecc_clear: assert property (p_ecc_clear)
		else $error("ecc error not released after status read");

	property p_pci_div;
		1'b1 |=> pci_clock_in != $past(pci_clock_in);
	endproperty
	a_pci_div: assert property (p_pci_div)
		else $error("pci clock not host clock halved");

	property p_req_sync;
		$changed(reset_request_in_n) |-> $rose(pci_clock_in);
	endproperty
	a_req_sync: assert property (p_req_sync)
		else $error("request changed off the pci clock rise");

	c_cpu_release: cover property ($rose(processor_reset_out_n));
	c_ecc_raise: cover property ($fell(ecc_error_out_n));
	c_agent_float: cover property ($fell(symmetric_agent_request_oe));
endmodule

/* dv/testbench.sv */
/*
 * Bench joining both ends over the link; register port tasks and directed tests.
 * Assumes a 100 MHz clock and the hold count shortened to HOLD cycles.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 20;
	logic        clk, reset_n, wr, rd, ecc_single_err, ecc_multi_err;
	logic        sw_reset_req, test_mode_req, irq, gport_reset_n, nand_tree_out;
	logic        cpu_in_reset, chip_in_reset, agent_config_active, ecc_alarm;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	int          fail_count, total_checks;

	host_reset_if link ();
	host_reset_sequencer #(.HOLD_CYCLES(HOLD)) i_host_reset_sequencer (.clk, .reset_n, .link, .addr, .wdata,
		.wr, .rd, .rdata, .ecc_single_err, .ecc_multi_err, .irq, .gport_reset_n, .nand_tree_out);
	io_bridge_end i_io_bridge_end (.clk, .reset_n, .link, .sw_reset_req, .test_mode_req, .cpu_in_reset,
		.chip_in_reset, .agent_config_active, .ecc_alarm);
	host_reset_chk #(.HOLD_CYCLES(HOLD)) i_host_reset_chk (.clk, .reset_n, .addr, .rd,
		.ecc_single_err, .ecc_multi_err,
		.pci_clock_in(link.pci_clock_in), .reset_request_in_n(link.reset_request_in_n),
		.test_mode_select_n(link.test_mode_select_n), .processor_reset_out_n(link.processor_reset_out_n),
		.delayed_chip_reset_n(link.delayed_chip_reset_n), .ecc_error_out_n(link.ecc_error_out_n),
		.symmetric_agent_request_n(link.symmetric_agent_request_n),
		.symmetric_agent_request_oe(link.symmetric_agent_request_oe));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// one-cycle error event, line sampled one cycle after the taking edge
	task automatic pulse_ecc(input bit multi);
		@(posedge clk);
		ecc_single_err <= !multi;
		ecc_multi_err <= multi;
		@(posedge clk);
		ecc_single_err <= 1'b0;
		ecc_multi_err <= 1'b0;
		settle(1);
	endtask

	task automatic wait_cpu(input logic v);
		int n;
		n = 0;
		while (link.processor_reset_level_n !== v && n < 300) begin
			settle(1);
			n++;
		end
		chk(link.processor_reset_level_n, v);
	endtask

	task automatic summarize();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#200000;
		fail_count++;
		summarize();
	end

	initial begin
		fail_count = 0;
		total_checks = 0;
		{reset_n, wr, rd, ecc_single_err, ecc_multi_err, sw_reset_req, test_mode_req} = 7'h00;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		rd_reg(`REG_CONFIG, 32'h0000_0000);
		rd_reg(`REG_MASK, 32'h0000_0000);
		wait_cpu(1'b1);
		chk({link.delayed_chip_reset_level_n, link.symmetric_agent_request_level_n}, 32'h0);
		settle(2);
		chk({link.delayed_chip_reset_level_n, link.symmetric_agent_request_level_n}, 32'h3);
		rd_reg(`REG_STATE, 32'h0000_0003);
		chk({cpu_in_reset, chip_in_reset, agent_config_active}, 32'h0);
		rd_reg(`REG_STATUS, 32'h0000_0004);
		rd_reg(`REG_STATUS, 32'h0000_0000);
		wr_reg(`REG_CONFIG, 32'hffff_ffff);
		rd_reg(`REG_CONFIG, 32'h0000_0181);
		wr_reg(8'h10, 32'hffff_ffff);
		rd_reg(8'h10, 32'h0000_0000);
		$display("test power_on done");

		wr_reg(`REG_CONFIG, 32'h0000_0080);
		wr_reg(`REG_MASK, 32'h0000_0003);
		for (int i = 0; i < 2; i++) begin
			pulse_ecc(i[0]);
			chk({link.ecc_error_level_n, irq}, 32'h1);
			settle(3);
			chk({link.ecc_error_level_n, ecc_alarm}, 32'h1);
			rd_reg(`REG_STATUS, 32'h1 << i);
			chk({link.ecc_error_level_n, irq}, 32'h2);
		end
		$display("test ecc_report done");

		wr_reg(`REG_CONFIG, 32'h0000_0000);
		wr_reg(`REG_MASK, 32'h0000_0000);
		pulse_ecc(1'b1);
		chk({link.ecc_error_level_n, irq}, 32'h2);
		wr_reg(`REG_MASK, 32'h0000_0002);
		chk({link.ecc_error_level_n, irq}, 32'h3);
		rd_reg(`REG_STATUS, 32'h0000_0002);
		chk(irq, 32'h0);
		$display("test ecc_masked done");

		@(posedge clk);
		sw_reset_req <= 1'b1;
		@(posedge clk);
		sw_reset_req <= 1'b0;
		wait_cpu(1'b0);
		chk({gport_reset_n, link.delayed_chip_reset_level_n, link.symmetric_agent_request_level_n}, 32'h0);
		wait_cpu(1'b1);
		settle(2);
		chk({gport_reset_n, link.delayed_chip_reset_level_n, link.symmetric_agent_request_level_n}, 32'h7);
		rd_reg(`REG_STATUS, 32'h0000_0004);
		$display("test soft_reset done");

		@(posedge clk);
		test_mode_req <= 1'b1;
		settle(4);
		chk({link.processor_reset_oe, link.delayed_chip_reset_oe, link.ecc_error_oe}, 32'h0);
		wr_reg(`REG_CONFIG, 32'h0000_0001);
		settle(2);
		chk({nand_tree_out, link.processor_reset_oe}, 32'h3);
		@(posedge clk);
		test_mode_req <= 1'b0;
		settle(4);
		chk(nand_tree_out, 32'h0);
		$display("test test_mode done");
		summarize();
	end
endmodule
